/* verilog/rrt_top.sv */
// Radio control: carrier sense, power-up sequencer, readouts, AHB-Lite regs
//
// Behaviour
// - Carrier sense compares strength against level and gain
// - Status register shows carrier sense bit
// - Lock select 0100 puts carrier sense out
// - Power-down mode 11 selects auto sequencing
// - Auto mode reinterprets main register fields
// - Writing sequencer power-down one sleeps device
// - Trigger select one: wake on select fall
// - Trigger select zero: wake on data fall, only with separate data io set
// - Wake powers receiver, no carrier returns sleep
// - Receiver and carrier waits time the phases
// - Calibrate every, 16th, 256th sequence or never
// - Converter clock is crystal over 2(div+1)
// - Average offset readout, signed, FSK only
// - Instantaneous deviation readout, signed eight bits
// - Deviation updated once per demodulator clock
// - Lock select 1101 puts demodulator clock out
// - Shaping bit selects Gaussian FSK
// - Eight-bit transmit power register drives power
// - Carrier sense above level plus gain plus eight unless forced
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module rrt_top
  import rrt_pkg::*;
#(
  parameter int unsigned CNT_W = 12
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic psel_pin,
  input wire logic serial_data_pin,
  output logic lock_pin,
  // Receiver and demodulator_config_reg side
  input wire logic [7:0] rssi_strength,
  input wire logic [7:0] avg_offset_in,
  input wire logic [7:0] inst_dev_in,
  input wire logic cal_done,
  // Controls out
  output logic rx_enable,
  output logic core_power_down,
  output logic cal_start,
  output logic adc_clk,
  output logic demodulator_clock,
  output logic gfsk_enable,
  output logic [7:0] transmit_power_setting
);
  import rrt_pkg::*;

  if (CNT_W < 12 || CNT_W > 16)
  begin : g_chk
    $error("rrt_top: CNT_W must hold sixteen wait units");
  end

  typedef struct packed {
    logic [7:0] main_r;
    logic [7:0] seq_r;
    logic sep_io;
    logic [10:0] carr_r;
    logic [3:0] lock_r;
    logic [15:0] demodulator_config_reg_r;
    logic shaping;
    logic [7:0] pa_r;
    logic dp_valid;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic [2:0] psel_s;
    logic [2:0] dio_s;
    rrt_seq_t st;
    logic [CNT_W-1:0] cnt;
    logic [7:0] nseq;
    logic [7:0] avg_offset;
    logic [7:0] inst_dev;
  } rrt_state_t;

  rrt_state_t q;
  rrt_state_t d;
  rrt_clk_if ck ();

  logic auto_mode;
  logic carrier_sense;
  logic [7:0] cs_thresh;
  logic psel_fall;
  logic dio_fall;
  logic trig;
  logic cal_due;
  logic sequencer_power_down_bit_wr;
  logic [CNT_W-1:0] rx_wait_cyc;
  logic [CNT_W-1:0] cs_wait_cyc;

  // ==========================================================================
  // Clock generator
  assign ck.adc_div = q.demodulator_config_reg_r[DEMODULATOR_CONFIG_REG_ADC_LSB +: 3];
  assign ck.baud_div = q.demodulator_config_reg_r[DEMODULATOR_CONFIG_REG_BAUD_LSB +: 8];

  rrt_clkgen #(
    .DIV_W(8)
  ) u_clkgen (
    .clk(clk),
    .nrst(nrst),
    .ck(ck.gen)
  );

  // ==========================================================================
  // Carrier sense and decode
  always_comb
  begin
    // threshold from level and maximum gain
    cs_thresh = {3'h0, q.carr_r[CARR_LVL_LSB +: 5]} + CS_MARGIN
      + {3'h0, q.carr_r[CARR_GAIN_LSB +: 5]};
    // above level plus gain plus eight, or forced
    carrier_sense = q.carr_r[CARR_FORCE_BIT] | (rssi_strength > cs_thresh);
  end

  assign auto_mode = q.main_r[MAIN_PDM_LSB +: 2] == PDM_AUTO;
  // Only the second and third sync stages feed the edge detectors
  assign psel_fall = q.psel_s[2] & ~q.psel_s[1];
  assign dio_fall = q.dio_s[2] & ~q.dio_s[1];
  // select pin edge when trigger bit set
  // data pin edge needs separate data io
  assign trig = q.seq_r[SEQUENCE_TRIGGER_SELECT_BIT_BIT] ? psel_fall : (q.sep_io & dio_fall);
  assign sequencer_power_down_bit_wr = q.dp_valid & q.dp_wr & (q.dp_addr == ADDR_MAIN)
    & (hwdata[MAIN_PDM_LSB +: 2] == PDM_AUTO) & hwdata[MAIN_PD_BIT];
  assign rx_wait_cyc = CNT_W'((32'(q.seq_r[SEQ_RXW_LSB +: 3]) + 32'd1) * SEQ_UNIT_CYC);
  assign cs_wait_cyc = CNT_W'((32'(q.seq_r[SEQ_CSW_LSB +: 4]) + 32'd1) * SEQ_UNIT_CYC);

  always_comb
  begin
    case (q.main_r[MAIN_CAL_LSB +: 2])
      SEQCAL_EVERY: cal_due = 1'b1;
      SEQCAL_16: cal_due = q.nseq[3:0] == 4'h0;
      SEQCAL_256: cal_due = q.nseq == 8'h00;
      default: cal_due = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    d = q;
    d.psel_s = {q.psel_s[1:0], psel_pin};
    d.dio_s = {q.dio_s[1:0], serial_data_pin};

    // Bus address phase; reads sample registers here, zero wait states
    d.dp_valid = hsel & htrans[1] & hready;
    d.dp_wr = hwrite;
    d.dp_addr = haddr[7:0];
    d.rdata = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_MAIN: d.rdata[7:0] = q.main_r;
      ADDR_SEQ: d.rdata[7:0] = q.seq_r;
      ADDR_IFACE: d.rdata[0] = q.sep_io;
      ADDR_CARR: d.rdata[10:0] = q.carr_r;
      ADDR_LOCK: d.rdata[3:0] = q.lock_r;
      ADDR_DEMODULATOR_CONFIG_REG: d.rdata[15:0] = q.demodulator_config_reg_r;
      ADDR_DEV: d.rdata[0] = q.shaping;
      ADDR_PA: d.rdata[7:0] = q.pa_r;
      ADDR_STATUS:
      begin
        d.rdata[STAT_PD_BIT] = core_power_down;
        d.rdata[STAT_CS_BIT] = carrier_sense;
        d.rdata[STAT_ST_LSB +: 3] = q.st;
      end
      ADDR_AVG: d.rdata[7:0] = q.avg_offset;
      ADDR_INST: d.rdata[7:0] = q.inst_dev;
      default: d.rdata = 32'h0000_0000;
    endcase

    // Bus data phase write; unmapped offsets ignore writes
    if (q.dp_valid && q.dp_wr)
    begin
      case (q.dp_addr)
        ADDR_MAIN: d.main_r = hwdata[7:0];
        ADDR_SEQ: d.seq_r = hwdata[7:0];
        ADDR_IFACE: d.sep_io = hwdata[0];
        ADDR_CARR: d.carr_r = hwdata[10:0];
        ADDR_LOCK: d.lock_r = hwdata[3:0];
        ADDR_DEMODULATOR_CONFIG_REG: d.demodulator_config_reg_r = hwdata[15:0];
        ADDR_DEV: d.shaping = hwdata[0];
        ADDR_PA: d.pa_r = hwdata[7:0];
        default: d.pa_r = q.pa_r;
      endcase
    end

    // average offset, frozen while in on-off keying
    if (!q.demodulator_config_reg_r[DEMODULATOR_CONFIG_REG_OOK_BIT])
      d.avg_offset = avg_offset_in;
    if (ck.demod_tick)
      d.inst_dev = inst_dev_in;

    // wake, listen, sleep again without carrier
    case (q.st)
      RRT_OFF:
        if (auto_mode)
          d.st = RRT_SLEEP;
      RRT_SLEEP:
        if (trig)
        begin
          d.nseq = q.nseq + 8'h01;
          d.cnt = rx_wait_cyc;
          d.st = cal_due ? RRT_CAL : RRT_RXWAIT;
        end
      RRT_CAL:
        if (cal_done)
        begin
          d.cnt = rx_wait_cyc;
          d.st = RRT_RXWAIT;
        end
      RRT_RXWAIT:
        if (q.cnt <= CNT_W'(1))
        begin
          d.cnt = cs_wait_cyc;
          d.st = RRT_CSWAIT;
        end
        else
          d.cnt = q.cnt - CNT_W'(1);
      RRT_CSWAIT:
        if (carrier_sense)
          d.st = RRT_RXON;
        else if (q.cnt <= CNT_W'(1))
          d.st = RRT_SLEEP;
        else
          d.cnt = q.cnt - CNT_W'(1);
      RRT_RXON:
        d.st = RRT_RXON;
      default:
        d.st = RRT_OFF;
    endcase
    // power-down write wins over the sequence
    if (!auto_mode)
      d.st = RRT_OFF;
    else if (sequencer_power_down_bit_wr)
      d.st = RRT_SLEEP;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.main_r <= MAIN_RST;
      q.seq_r <= SEQ_RST;
      q.carr_r <= CARR_RST;
      q.lock_r <= LOCK_RST;
      q.demodulator_config_reg_r <= DEMODULATOR_CONFIG_REG_RST;
      q.pa_r <= PA_RST;
      q.st <= RRT_OFF;
    end
    else
      q <= d;
  end

  // ==========================================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign adc_clk = ck.adc_clk;
  assign demodulator_clock = ck.demod_clk;
  assign gfsk_enable = q.shaping;
  // power word straight to the amplifier
  assign transmit_power_setting = q.pa_r;
  assign cal_start = q.st == RRT_CAL;

  // main fields read as sequencer controls in auto mode
  always_comb
  begin
    if (auto_mode)
    begin
      rx_enable = (q.st == RRT_RXWAIT) | (q.st == RRT_CSWAIT) | (q.st == RRT_RXON);
      core_power_down = (q.st == RRT_SLEEP) | (q.st == RRT_OFF);
    end
    else
    begin
      rx_enable = q.main_r[MAIN_RX_BIT];
      core_power_down = q.main_r[MAIN_PD_BIT];
    end
  end

  always_comb
  begin
    case (q.lock_r)
      LOCK_SEL_CS: lock_pin = carrier_sense;
      LOCK_SEL_DEMOD: lock_pin = ck.demod_clk;
      default: lock_pin = 1'b0;
    endcase
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_asleep_psel;
    q.st == RRT_SLEEP && q.seq_r[SEQUENCE_TRIGGER_SELECT_BIT_BIT] && auto_mode && !sequencer_power_down_bit_wr;
  endsequence
  sequence s_fall_seen;
    q.psel_s[2] && !q.psel_s[1];
  endsequence
  sequence s_cs_timeout;
    q.st == RRT_CSWAIT && !carrier_sense && q.cnt == CNT_W'(1) && auto_mode
      && !sequencer_power_down_bit_wr;
  endsequence

  a_lock_cs_route: assert property (q.lock_r == LOCK_SEL_CS |-> lock_pin == carrier_sense)
    else $error("lock pin does not show carrier sense");
  a_lock_dm_route: assert property (q.lock_r == LOCK_SEL_DEMOD |-> lock_pin == ck.demod_clk)
    else $error("lock pin does not show demodulator clock");
  a_cs_threshold: assert property (!q.carr_r[CARR_FORCE_BIT]
    && rssi_strength == cs_thresh |-> !carrier_sense)
    else $error("carrier sense set at threshold");
  a_status_cs_bit: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[7:0] == ADDR_STATUS |=> hrdata[STAT_CS_BIT] == $past(carrier_sense))
    else $error("status carrier sense bit wrong");
  a_mode_off_state: assert property (!auto_mode |=> q.st == RRT_OFF)
    else $error("sequencer active outside auto mode");
  a_sequencer_power_down_bit_sleep: assert property (auto_mode && sequencer_power_down_bit_wr
    |=> q.st == RRT_SLEEP && core_power_down)
    else $error("sequencer power-down write ignored");
  a_psel_wake: assert property (s_asleep_psel ##0 s_fall_seen |=> q.st != RRT_SLEEP
    && q.nseq == $past(q.nseq) + 8'h01)
    else $error("select pin fall did not wake");
  a_cs_timeout: assert property (s_cs_timeout |=> q.st == RRT_SLEEP && !rx_enable)
    else $error("no carrier did not return to sleep");
  a_inst_hold: assert property (!ck.demod_tick |=> $stable(q.inst_dev))
    else $error("deviation readout moved between ticks");
  a_cal_never: assert property (q.main_r[MAIN_CAL_LSB +: 2] == 2'h3
    && q.st == RRT_SLEEP |=> q.st != RRT_CAL)
    else $error("calibration ran while disabled");

endmodule

/* verilog/rrt_pkg.sv */
// Constants, register map and types of the radio control block
package rrt_pkg;

  // ==========================================================================
  // Clock and sequencer timing
  localparam int unsigned CLK_MHZ = 200;
  // One step of the receiver and carrier sense wait fields
  localparam int unsigned SEQ_UNIT_NS = 1000;
  localparam int unsigned SEQ_UNIT_CYC = (SEQ_UNIT_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_MAIN = 8'h00;
  localparam logic [7:0] ADDR_SEQ = 8'h04;
  localparam logic [7:0] ADDR_IFACE = 8'h08;
  localparam logic [7:0] ADDR_CARR = 8'h0c;
  localparam logic [7:0] ADDR_LOCK = 8'h10;
  localparam logic [7:0] ADDR_DEMODULATOR_CONFIG_REG = 8'h14;
  localparam logic [7:0] ADDR_DEV = 8'h18;
  localparam logic [7:0] ADDR_PA = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_AVG = 8'h24;
  localparam logic [7:0] ADDR_INST = 8'h28;

  // ==========================================================================
  // Field positions
  localparam int unsigned MAIN_PDM_LSB = 0;
  localparam int unsigned MAIN_PD_BIT = 2;
  localparam int unsigned MAIN_RX_BIT = 3;
  localparam int unsigned MAIN_CAL_LSB = 3;
  localparam int unsigned SEQUENCE_TRIGGER_SELECT_BIT_BIT = 0;
  localparam int unsigned SEQ_RXW_LSB = 1;
  localparam int unsigned SEQ_CSW_LSB = 4;
  localparam int unsigned CARR_LVL_LSB = 0;
  localparam int unsigned CARR_GAIN_LSB = 5;
  localparam int unsigned CARR_FORCE_BIT = 10;
  localparam int unsigned DEMODULATOR_CONFIG_REG_ADC_LSB = 0;
  localparam int unsigned DEMODULATOR_CONFIG_REG_OOK_BIT = 3;
  localparam int unsigned DEMODULATOR_CONFIG_REG_BAUD_LSB = 8;
  localparam int unsigned STAT_PD_BIT = 0;
  localparam int unsigned STAT_CS_BIT = 3;
  localparam int unsigned STAT_ST_LSB = 4;

  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] SEQ_RST = 8'h00;
  localparam logic [10:0] CARR_RST = 11'h000;
  localparam logic [3:0] LOCK_RST = 4'h0;
  localparam logic [15:0] DEMODULATOR_CONFIG_REG_RST = 16'h0000;
  localparam logic [7:0] PA_RST = 8'h00;
  localparam logic [1:0] PDM_AUTO = 2'h3;
  localparam logic [3:0] LOCK_SEL_CS = 4'h4;
  localparam logic [3:0] LOCK_SEL_DEMOD = 4'hd;
  localparam logic [7:0] CS_MARGIN = 8'h08;
  localparam logic [1:0] SEQCAL_EVERY = 2'h0;
  localparam logic [1:0] SEQCAL_16 = 2'h1;
  localparam logic [1:0] SEQCAL_256 = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    RRT_OFF = 3'b000,
    RRT_SLEEP = 3'b001,
    RRT_CAL = 3'b010,
    RRT_RXWAIT = 3'b011,
    RRT_CSWAIT = 3'b100,
    RRT_RXON = 3'b101
  } rrt_seq_t;

endpackage

/* verilog/rrt_clk_if.sv */
// Divider settings and derived clocks between control and clock generator
`timescale 1ns/1ps
interface rrt_clk_if;
  logic [2:0] adc_div;
  logic [7:0] baud_div;
  logic adc_clk;
  logic demod_clk;
  logic demod_tick;
  modport gen (input adc_div, input baud_div, output adc_clk, output demod_clk,
    output demod_tick);
  modport usr (output adc_div, output baud_div, input adc_clk, input demod_clk,
    input demod_tick);
endinterface

/* verilog/rrt_clkgen.sv */
// Converter clock and demodulator clock dividers
`timescale 1ns/1ps
module rrt_clkgen
  import rrt_pkg::*;
#(
  parameter int unsigned DIV_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Settings in, clocks out
  rrt_clk_if.gen ck
);
  import rrt_pkg::*;

  if (DIV_W != 8)
  begin : g_chk
    $error("rrt_clkgen: DIV_W must match the baud divider field");
  end

  typedef struct packed {
    logic [2:0] adc_cnt;
    logic adc_clk;
    logic [DIV_W-1:0] dm_cnt;
    logic dm_clk;
    logic dm_tick;
  } rrt_cg_t;

  rrt_cg_t q;
  rrt_cg_t d;

  // ==========================================================================
  // Dividers
  always_comb
  begin
    d = q;
    d.dm_tick = 1'b0;
    if (q.adc_cnt >= ck.adc_div)
    begin
      d.adc_cnt = 3'h0;
      d.adc_clk = ~q.adc_clk;
    end
    else
      d.adc_cnt = q.adc_cnt + 3'h1;
    if (q.dm_cnt >= ck.baud_div)
    begin
      d.dm_cnt = '0;
      d.dm_clk = ~q.dm_clk;
      d.dm_tick = ~q.dm_clk;
    end
    else
      d.dm_cnt = q.dm_cnt + DIV_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  assign ck.adc_clk = q.adc_clk;
  assign ck.demod_clk = q.dm_clk;
  // Tick is high for the one cycle after the demodulator clock rises
  assign ck.demod_tick = q.dm_tick;
endmodule

/* tb/rrt_host_model.sv */
// Host controller model: AHB-Lite master and wake pins
`timescale 1ns/1ps
module rrt_host_model
  import rrt_pkg::*;
(
  // Clock
  input wire logic clk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Wake pins, idle high
  output logic psel_pin,
  output logic serial_data_pin
);
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    psel_pin = 1'b1;
    serial_data_pin = 1'b1;
  end

  // ==========================================================================
  // Single word transfer; never assumes a wait count
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    for (n = 0; n == 0 || (!hready && n < 50); n++)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (n = 0; n == 0 || (!hready && n < 50); n++)
      @(posedge clk);
    rd = hrdata;
    if (!hready)
      rrt_tb_top.hang();
  endtask

  task automatic ramp(input logic [7:0] target);
    logic [31:0] d;
    for (int i = 0; i < 16; i++)
      xfer(ADDR_PA, 1'b1, 32'(i), d);
    xfer(ADDR_PA, 1'b1, 32'h50, d);
    xfer(ADDR_PA, 1'b1, {24'h0, target}, d);
  endtask

  // Pulse a wake pin low long enough to pass the synchroniser
  task automatic fall(input logic use_sel);
    @(posedge clk);
    if (use_sel)
      psel_pin <= 1'b0;
    else
      serial_data_pin <= 1'b0;
    repeat (4) @(posedge clk);
    psel_pin <= 1'b1;
    serial_data_pin <= 1'b1;
  endtask
endmodule

/* tb/rrt_tb_top.sv */
// Self-checking bench of the radio control block
`timescale 1ns/1ps
module rrt_tb_top;
  import rrt_pkg::*;
  // ==========================================================================
  // Signals
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, psel_pin, serial_data_pin, lock_pin;
  logic cal_done, rx_enable, core_power_down, cal_start, adc_clk, demodulator_clock;
  logic gfsk_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rssi_strength, avg_offset_in, inst_dev_in, transmit_power_setting, v;
  logic [4:0] lvl, gain;
  int fails, check_count, p, k, a, b;

  rrt_top rrt_top_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .psel_pin(psel_pin),
    .serial_data_pin(serial_data_pin), .lock_pin(lock_pin), .rssi_strength(rssi_strength),
    .avg_offset_in(avg_offset_in), .inst_dev_in(inst_dev_in), .cal_done(cal_done),
    .rx_enable(rx_enable), .core_power_down(core_power_down), .cal_start(cal_start),
    .adc_clk(adc_clk), .demodulator_clock(demodulator_clock), .gfsk_enable(gfsk_enable),
    .transmit_power_setting(transmit_power_setting));
  rrt_host_model rrt_host_model_i (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .psel_pin(psel_pin), .serial_data_pin(serial_data_pin));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    fails++;
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    rrt_host_model_i.xfer(ad, 1'b1, d, rd);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    rrt_host_model_i.xfer(ad, 1'b0, 32'h0, rd);
    chk(rd, e);
  endtask

  function automatic logic cs_exp(input logic [7:0] s, input logic [4:0] l,
    input logic [4:0] g, input logic f);
    return f | ({1'b0, s} > (9'(l) + 9'h008 + 9'(g)));
  endfunction

  // Cycles between two rising edges of a divided clock
  task automatic period(input logic dm, output int q);
    logic prev, cur;
    int e;
    e = 0;
    q = 0;
    prev = 1'b1;
    for (int n = 0; n < 200 && e < 2; n++)
    begin
      @(posedge clk);
      cur = dm ? demodulator_clock : adc_clk;
      if (e == 1)
        q++;
      if (cur && !prev)
        e++;
      prev = cur;
    end
    if (e < 2)
      hang();
  endtask

  // One wake-up: trigger, calibrate if due, then poll state until fin
  task automatic wake(input logic sel, input logic cal, input logic [2:0] fin);
    longint t0;
    int el;
    logic [31:0] st;
    t0 = $time;
    rrt_host_model_i.fall(sel);
    chk(32'(cal_start), 32'(cal));
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(rx_enable), 32'h1);
    st = 32'h0;
    for (el = 0; el < 400 && st[6:4] !== fin; el++)
      rrt_host_model_i.xfer(ADDR_STATUS, 1'b0, 32'h0, st);
    el = int'(($time - t0) / 5);
    chk(32'(st[6:4]), 32'(fin));
    // Rx wait of 1 gives two units; slack covers sync and polling
    chk(32'(el >= 2 * SEQ_UNIT_CYC && el <= 3 * SEQ_UNIT_CYC + 20), 32'h1);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    {cal_done, rssi_strength, avg_offset_in, inst_dev_in} = '0;
    fails = 0;
    check_count = 0;
    void'($urandom(52));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(ADDR_PA, {24'h0, PA_RST});
    rdc(ADDR_STATUS, 32'h0);
    rdc(8'h3c, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("test reset done");
    v = 8'($urandom());
    rrt_host_model_i.ramp(v);
    repeat (3) @(posedge clk);
    chk(32'(transmit_power_setting), 32'(v));
    rdc(ADDR_PA, {24'h0, v});
    // amplifier held sixteen bit periods before power-off
    repeat (32) @(posedge clk);
    wr(ADDR_PA, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(transmit_power_setting), 32'h0);
    for (k = 1; k >= 0; k--)
    begin
      wr(ADDR_DEV, 32'(k));
      repeat (3) @(posedge clk);
      chk(32'(gfsk_enable), 32'(k));
    end
    $display("test transmit done");
    lvl = 5'($urandom());
    gain = 5'($urandom());
    wr(ADDR_LOCK, 32'(LOCK_SEL_CS));
    // Just below, at and above the threshold, then forced from below
    for (k = 0; k < 4; k++)
    begin
      v = 8'(lvl) + 8'(gain) + 8'h07 + ((k == 3) ? 8'h00 : 8'(k));
      wr(ADDR_CARR, 32'({k == 3, gain, lvl}));
      rssi_strength <= v;
      repeat (4) @(posedge clk);
      rdc(ADDR_STATUS, {28'h0, cs_exp(v, lvl, gain, k == 3), 3'h0});
      chk(32'(lock_pin), 32'(cs_exp(v, lvl, gain, k == 3)));
    end
    $display("test carrier done");
    a = $urandom() % 8;
    b = 3 + $urandom() % 4;
    wr(ADDR_DEMODULATOR_CONFIG_REG, {16'h0, 8'(b), 5'h00, 3'(a)});
    period(1'b0, p);
    chk(32'(p), 32'(2 * (a + 1)));
    period(1'b1, p);
    chk(32'(p), 32'(2 * (b + 1)));
    wr(ADDR_LOCK, 32'(LOCK_SEL_DEMOD));
    repeat (20)
    begin
      @(posedge clk);
      #1 chk(32'(lock_pin), 32'(demodulator_clock));
    end
    wr(ADDR_LOCK, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(lock_pin), 32'h0);
    v = 8'($urandom());
    inst_dev_in <= v;
    period(1'b1, p);
    // read just after a demod tick
    inst_dev_in <= ~v;
    rdc(ADDR_INST, {24'h0, v});
    avg_offset_in <= v;
    repeat (3) @(posedge clk);
    rdc(ADDR_AVG, {24'h0, v});
    wr(ADDR_DEMODULATOR_CONFIG_REG, 32'h0000_0008);
    avg_offset_in <= ~v;
    repeat (3) @(posedge clk);
    rdc(ADDR_AVG, {24'h0, v});
    // retuning from this offset is the host's own job
    $display("test readout done");
    rssi_strength <= 8'h00;
    wr(ADDR_CARR, 32'h0);
    // Normal mode: main fields drive receiver and power-down directly
    wr(ADDR_MAIN, 32'h0000_000c);
    @(posedge clk);
    chk(32'({rx_enable, core_power_down}), 32'h3);
    wr(ADDR_SEQ, 32'h0000_0003);
    wr(ADDR_MAIN, 32'h0000_001f);
    repeat (3) @(posedge clk);
    chk(32'(core_power_down), 32'h1);
    rdc(ADDR_STATUS, 32'h0000_0011);
    rrt_host_model_i.fall(1'b0);
    repeat (4) @(posedge clk);
    rdc(ADDR_STATUS, 32'h0000_0011);
    wake(1'b1, 1'b0, RRT_SLEEP);
    rssi_strength <= 8'hff;
    wr(ADDR_SEQ, 32'h0000_0002);
    wr(ADDR_IFACE, 32'h0000_0001);
    wr(ADDR_MAIN, 32'h0000_0007);
    wake(1'b0, 1'b1, RRT_RXON);
    wr(ADDR_MAIN, 32'h0000_001f);
    repeat (3) @(posedge clk);
    chk(32'(core_power_down), 32'h1);
    $display("test sequencer done");
    tally_and_finish();
  end
endmodule
